// ---- rtl/tcc_defs.vh ----
`ifndef TCC_DEFS_VH
`define TCC_DEFS_VH
// ----------------------------------------
// register indices (byte address = index * 4)
// ----------------------------------------
`define TCC_IDX_CH0_LO 8'hda
`define TCC_IDX_CH0_HI 8'hdb
`define TCC_IDX_CH1_LO 8'hdc
`define TCC_IDX_CH1_HI 8'hdd
`define TCC_IDX_CH2_LO 8'hde
`define TCC_IDX_CH2_HI 8'hdf
`define TCC_IDX_CTL1 8'he6
`define TCC_IDX_CTL2 8'he7
`define TCC_IDX_TMODE 8'he8
`define TCC_IDX_CNT_LO 8'he9
`define TCC_IDX_CNT_HI 8'hea
`define TCC_IDX_FLAGS 8'heb
`define TCC_IDX_STEP 8'h02
// ----------------------------------------
// control register fields
// ----------------------------------------
`define TCC_SRC_BIT 7
`define TCC_MASK_BIT 6
`define TCC_CMP_HI 5
`define TCC_CMP_LO 3
`define TCC_MODE_BIT 2
`define TCC_CAP_RISE 0
`define TCC_CAP_FALL 1
`define TCC_EDGE_RISE 2'h1
`define TCC_EDGE_FALL 2'h2
`define TCC_EDGE_BOTH 2'h3
`define TCC_CTL_RST 8'h40
`define TCC_BYTE_RST 8'h00
`define TCC_WORD_RST 16'h0000
`define TCC_WORD_ONE 16'h0001
// ----------------------------------------
// compare action codes
// ----------------------------------------
`define TCC_CMP_SET 3'h0
`define TCC_CMP_CLR 3'h1
`define TCC_CMP_TGL 3'h2
`define TCC_CMP_SET_UP 3'h3
`define TCC_CMP_CLR_UP 3'h4
`define TCC_CMP_CLR0_SET 3'h5
`define TCC_CMP_SET0_CLR 3'h6
`define TCC_CMP_DSM 3'h7
// ----------------------------------------
// counter modes and modulator rates
// ----------------------------------------
`define TCC_TM_STOP 2'h0
`define TCC_TM_FREE 2'h1
`define TCC_TM_MODULO 2'h2
`define TCC_TM_UPDOWN 2'h3
`define TCC_DSM_LAST8 3'h7
`define TCC_DSM_LAST4 3'h3
`define TCC_DIV_RST 3'h0
`define TCC_DIV_ONE 3'h1
`endif

// ---- rtl/tcc_timer_capcmp.v ----
// Behaviour
// RL1: channel 1 captures from pin when source bit 7 clear, radio event when set.
// RL2: channel 2 captures from radio event when its source bit set, else pin.
// RL3: channel 1 interrupt forwarded only while mask bit 6 set; resets to 1.
// RL4: channel 2 interrupt forwarded only while its mask bit 6 set; resets to 1.
// RL5: on compare match codes 000/001/010 set, clear, toggle the output.
// RL6: code 011 sets on up match, clears at zero or on down match.
// RL7: code 100 clears on up match, sets at zero or on down match.
// RL8: channel 1 code 101 clears on chan0 match, sets on chan1 match; 110 opposite.
// RL9: channel 2 code 101/110 likewise with chan2 value; code 111 unused.
// RL10: channel 1 code 111 enables modulator; mode bit picks timer/8 or timer/4.
// RL11: outside modulator mode, mode bit 2 selects capture (0) or compare (1).
// RL12: edge bits: 00 none, 01 rising, 10 falling, 11 both edges.
// RL13: modulator low bits: 00 both, 01 interpolator, 10 shaping, 11 neither.
// RL14: channel 1 value is high and low byte registers, both read/write.
// RL15: in modulator mode value is modulator data; two low bits ignored.
// RL16: channel 2 value high byte resets to zero and is read/write.
// RL17: channel flags set on their condition; writing 0 clears, writing 1 nothing.
// RL18: modulo counts zero to chan0 value; up/down counts up then back to zero.
// RL19: capture copies counter into the channel value and raises its condition.
`timescale 1ns/1ps
`include "tcc_defs.vh"
module tcc_timer_capcmp (
   input wire sys_clk_in,
   input wire arst_n_in,
   input wire wb_cyc_in,
   input wire wb_stb_in,
   input wire wb_we_in,
   input wire [9:0] wb_adr_in,
   input wire [3:0] wb_sel_in,
   input wire [31:0] wb_dat_in,
   output reg [31:0] wb_dat_out,
   output reg wb_ack_out,
   input wire [1:0] capture_pin_in,
   input wire radio_interrupt_event_in,
   output reg [1:0] channel_out,
   output reg irq_out
);
   // ----------------------------------------
   // bus slave
   // ----------------------------------------
   wire [7:0] idx = wb_adr_in[9:2];
   wire req = wb_cyc_in & wb_stb_in;
   // writes land at the edge where the master sees ack
   wire wr = req & wb_we_in & wb_ack_out & wb_sel_in[0];
   wire [7:0] wd = wb_dat_in[7:0];
   reg [7:0] rd_mux;
   // ----------------------------------------
   // register write strobes
   // ----------------------------------------
   wire wr_tmode = wr && (idx == `TCC_IDX_TMODE);
   wire wr_cnt = wr && (idx == `TCC_IDX_CNT_LO);
   wire wr_cc0_lo = wr && (idx == `TCC_IDX_CH0_LO);
   wire wr_cc0_hi = wr && (idx == `TCC_IDX_CH0_HI);
   wire wr_flags = wr && (idx == `TCC_IDX_FLAGS);
   // ----------------------------------------
   // counter and shared registers
   // ----------------------------------------
   reg [15:0] cnt_q;
   reg [15:0] cnt_d;
   reg down_q;
   reg down_d;
   reg [1:0] tmode_q;
   reg [15:0] cc0_q;
   reg [1:0] flag_q;
   wire [1:0] evt;
   wire [1:0] mask;
   wire [15:0] ctl_all;
   wire [31:0] val_all;
   wire run = (tmode_q != `TCC_TM_STOP);
   wire updown = (tmode_q == `TCC_TM_UPDOWN);
   wire zero_hit = run & (cnt_q == `TCC_WORD_RST);
   // codes 101/110: the channel's own hit outranks this one
   wire c0_hit = run & (cnt_q == cc0_q);
   always @* begin
      cnt_d = cnt_q;
      down_d = down_q;
      case (tmode_q)
         `TCC_TM_FREE: begin
            cnt_d = cnt_q + `TCC_WORD_ONE;
            down_d = 1'b0;
         end
         `TCC_TM_MODULO: begin
            if (cnt_q == cc0_q) begin
               cnt_d = `TCC_WORD_RST; // [RL18]
            end else begin
               cnt_d = cnt_q + `TCC_WORD_ONE;
            end
            down_d = 1'b0;
         end
         `TCC_TM_UPDOWN: begin
            // turn around at the top and at zero [RL18]
            if (!down_q) begin
               if (cnt_q == cc0_q) begin
                  // a zero top value parks the counter instead of wrapping below zero
                  if (cc0_q != `TCC_WORD_RST) begin
                     down_d = 1'b1;
                     cnt_d = cnt_q - `TCC_WORD_ONE;
                  end else begin
                     down_d = 1'b0;
                     cnt_d = cnt_q;
                  end
               end else begin
                  cnt_d = cnt_q + `TCC_WORD_ONE;
               end
            end else begin
               if (cnt_q == `TCC_WORD_RST) begin
                  down_d = 1'b0;
                  cnt_d = cnt_q + `TCC_WORD_ONE;
               end else begin
                  cnt_d = cnt_q - `TCC_WORD_ONE;
               end
            end
         end
         default: begin
            cnt_d = cnt_q;
            down_d = down_q;
         end
      endcase
   end
   always @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         cnt_q <= `TCC_WORD_RST;
         down_q <= 1'b0;
         tmode_q <= `TCC_TM_STOP;
         cc0_q <= `TCC_WORD_RST;
      end else begin
         // any write to the low count byte restarts from zero
         if (wr_cnt) begin
            cnt_q <= `TCC_WORD_RST;
            down_q <= 1'b0;
         end else begin
            cnt_q <= cnt_d;
            down_q <= down_d;
         end
         if (wr_tmode) begin
            tmode_q <= wd[1:0];
         end
         if (wr_cc0_lo) begin
            cc0_q[7:0] <= wd;
         end
         if (wr_cc0_hi) begin
            cc0_q[15:8] <= wd;
         end
      end
   end
   // ----------------------------------------
   // delta-sigma modulator (channel 1 only)
   // ----------------------------------------
   wire [7:0] ctl1 = ctl_all[7:0];
   wire dsm_on = (ctl1[`TCC_CMP_HI:`TCC_CMP_LO] == `TCC_CMP_DSM); // [RL10]
   wire dsm_fast = ctl1[`TCC_MODE_BIT];
   wire interp_en = ~ctl1[`TCC_CAP_FALL]; // [RL13]
   wire shape_en = ~ctl1[`TCC_CAP_RISE]; // [RL13]
   reg [2:0] div_q;
   reg [15:0] smp_cur_q;
   reg [15:0] smp_prev_q;
   reg [15:0] acc_q;
   reg raw_q;
   reg dsm_bit_q;
   wire upd = dsm_on & (div_q == (dsm_fast ? `TCC_DSM_LAST4 : `TCC_DSM_LAST8)); // [RL10]
   wire [16:0] avg_sum = {1'b0, smp_prev_q} + {1'b0, smp_cur_q};
   // interpolator trades one update of latency for half-size steps
   wire [15:0] dsm_in = interp_en ? avg_sum[16:1] : smp_cur_q;
   wire [16:0] acc_sum = {1'b0, acc_q} + {1'b0, dsm_in};
   wire [15:0] val1 = val_all[15:0];
   always @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         div_q <= `TCC_DIV_RST;
         smp_cur_q <= `TCC_WORD_RST;
         smp_prev_q <= `TCC_WORD_RST;
         acc_q <= `TCC_WORD_RST;
         raw_q <= 1'b0;
         dsm_bit_q <= 1'b0;
      end else if (!dsm_on) begin
         // leaving modulator mode restarts the accumulator from zero
         div_q <= `TCC_DIV_RST;
         acc_q <= `TCC_WORD_RST;
         raw_q <= 1'b0;
         dsm_bit_q <= 1'b0;
      end else begin
         if (upd) begin
            div_q <= `TCC_DIV_RST;
            smp_prev_q <= smp_cur_q;
            smp_cur_q <= {val1[15:2], 2'b00}; // [RL15]
         end else begin
            div_q <= div_q + `TCC_DIV_ONE;
         end
         // the accumulator carry is the raw modulator bit
         acc_q <= acc_sum[15:0];
         raw_q <= acc_sum[16];
         // shaping drops single-cycle pulses: output moves only on two equal bits
         if (!shape_en || raw_q == acc_sum[16]) begin
            dsm_bit_q <= acc_sum[16];
         end
      end
   end
   // ----------------------------------------
   // channels 1 and 2
   // ----------------------------------------
   genvar c;
   generate
      for (c = 0; c < 2; c = c + 1) begin : g_ch
         reg [7:0] ctl_q;
         reg [15:0] val_q;
         reg src_prev_q;
         wire [2:0] cmp = ctl_q[`TCC_CMP_HI:`TCC_CMP_LO];
         wire dsm_here = (c == 0) && dsm_on;
         wire cmp_mode = ctl_q[`TCC_MODE_BIT] & ~dsm_here; // [RL11]
         wire src = ctl_q[`TCC_SRC_BIT] ? radio_interrupt_event_in : capture_pin_in[c]; // [RL1] [RL2]
         wire rise = src & ~src_prev_q;
         wire fall = ~src & src_prev_q;
         // ----------------------------------------
         // capture edge decode
         // ----------------------------------------
         reg edge_hit;
         always @* begin
            case (ctl_q[`TCC_CAP_FALL:`TCC_CAP_RISE])
               `TCC_EDGE_RISE: edge_hit = rise; // [RL12]
               `TCC_EDGE_FALL: edge_hit = fall; // [RL12]
               `TCC_EDGE_BOTH: edge_hit = rise | fall; // [RL12]
               default: edge_hit = 1'b0;
            endcase
         end
         wire trig = ~cmp_mode & ~dsm_here & edge_hit;
         wire hit = run & (cnt_q == val_q);
         wire up_hit = hit & ~down_q;
         wire down_hit = hit & down_q;
         wire back_hit = updown ? down_hit : zero_hit;
         wire [31:0] lo_sum = `TCC_IDX_CH1_LO + c * `TCC_IDX_STEP;
         wire [31:0] hi_sum = `TCC_IDX_CH1_HI + c * `TCC_IDX_STEP;
         wire [31:0] ctl_sum = `TCC_IDX_CTL1 + c;
         // only the low byte of each sum is an index
         wire [7:0] lo_idx = lo_sum[7:0];
         wire [7:0] hi_idx = hi_sum[7:0];
         wire [7:0] ctl_idx = ctl_sum[7:0];
         assign evt[c] = trig | (cmp_mode & hit); // [RL19]
         assign mask[c] = ctl_q[`TCC_MASK_BIT];
         assign ctl_all[c*8 +: 8] = ctl_q;
         assign val_all[c*16 +: 16] = val_q;
         always @(posedge sys_clk_in or negedge arst_n_in) begin
            if (!arst_n_in) begin
               ctl_q <= `TCC_CTL_RST; // [RL3] [RL4]
               val_q <= `TCC_WORD_RST; // [RL16]
               src_prev_q <= 1'b0;
               channel_out[c] <= 1'b0;
            end else begin
               // edge history runs in every mode so a mode change cannot fake an edge
               src_prev_q <= src;
               if (wr && idx == ctl_idx) begin
                  ctl_q <= wd;
               end
               // a capture outranks a software write in the same cycle
               if (trig) begin
                  val_q <= cnt_q; // [RL19]
               end else begin
                  if (wr && idx == lo_idx) begin
                     val_q[7:0] <= wd; // [RL14]
                  end
                  if (wr && idx == hi_idx) begin
                     val_q[15:8] <= wd; // [RL14] [RL16]
                  end
               end
               if (dsm_here) begin
                  channel_out[c] <= dsm_bit_q; // [RL10]
               end else if (cmp_mode) begin
                  case (cmp)
                     `TCC_CMP_SET: begin
                        if (hit) begin
                           channel_out[c] <= 1'b1; // [RL5]
                        end
                     end
                     `TCC_CMP_CLR: begin
                        if (hit) begin
                           channel_out[c] <= 1'b0; // [RL5]
                        end
                     end
                     `TCC_CMP_TGL: begin
                        if (hit) begin
                           channel_out[c] <= ~channel_out[c]; // [RL5]
                        end
                     end
                     `TCC_CMP_SET_UP: begin
                        if (up_hit) begin
                           channel_out[c] <= 1'b1; // [RL6]
                        end else if (back_hit) begin
                           channel_out[c] <= 1'b0; // [RL6]
                        end
                     end
                     `TCC_CMP_CLR_UP: begin
                        if (up_hit) begin
                           channel_out[c] <= 1'b0; // [RL7]
                        end else if (back_hit) begin
                           channel_out[c] <= 1'b1; // [RL7]
                        end
                     end
                     `TCC_CMP_CLR0_SET: begin
                        if (hit) begin
                           channel_out[c] <= 1'b1; // [RL8] [RL9]
                        end else if (c0_hit) begin
                           channel_out[c] <= 1'b0; // [RL8] [RL9]
                        end
                     end
                     `TCC_CMP_SET0_CLR: begin
                        if (hit) begin
                           channel_out[c] <= 1'b0; // [RL8] [RL9]
                        end else if (c0_hit) begin
                           channel_out[c] <= 1'b1; // [RL8] [RL9]
                        end
                     end
                     // channel 2 has no modulator, so code 111 there only holds
                     default: begin
                        channel_out[c] <= channel_out[c]; // [RL9]
                     end
                  endcase
               end
            end
         end
      end
   endgenerate
   // ----------------------------------------
   // flags and interrupt
   // ----------------------------------------
   always @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         flag_q <= 2'b00;
         irq_out <= 1'b0;
      end else begin
         // writing 0 clears, a fresh event in the same cycle wins [RL17]
         if (wr_flags) begin
            flag_q <= (flag_q & wd[1:0]) | evt;
         end else begin
            flag_q <= flag_q | evt;
         end
         // irq lags the flag by a cycle so that it comes straight from a flop
         irq_out <= |(flag_q & mask); // [RL3] [RL4]
      end
   end
   // ----------------------------------------
   // read mux and ack
   // ----------------------------------------
   // unmapped indices read zero but are still acked
   always @* begin
      case (idx)
         `TCC_IDX_CH0_LO: rd_mux = cc0_q[7:0];
         `TCC_IDX_CH0_HI: rd_mux = cc0_q[15:8];
         `TCC_IDX_CH1_LO: rd_mux = val_all[7:0]; // [RL14]
         `TCC_IDX_CH1_HI: rd_mux = val_all[15:8]; // [RL14]
         `TCC_IDX_CH2_LO: rd_mux = val_all[23:16];
         `TCC_IDX_CH2_HI: rd_mux = val_all[31:24]; // [RL16]
         `TCC_IDX_CTL1: rd_mux = ctl_all[7:0];
         `TCC_IDX_CTL2: rd_mux = ctl_all[15:8];
         `TCC_IDX_TMODE: rd_mux = {6'h00, tmode_q};
         `TCC_IDX_CNT_LO: rd_mux = cnt_q[7:0];
         `TCC_IDX_CNT_HI: rd_mux = cnt_q[15:8];
         `TCC_IDX_FLAGS: rd_mux = {6'h00, flag_q};
         default: rd_mux = `TCC_BYTE_RST;
      endcase
   end
   always @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         wb_ack_out <= 1'b0;
         wb_dat_out <= 32'h00000000;
      end else begin
         wb_ack_out <= req & ~wb_ack_out;
         if (req && !wb_ack_out) begin
            wb_dat_out <= {24'h000000, rd_mux};
         end
      end
   end
endmodule // tcc_timer_capcmp

// ---- verif/tcc_capcmp_asserts.sv ----
`timescale 1ns/1ps
module tcc_capcmp_asserts (
   input wire sys_clk_in,
   input wire arst_n_in,
   input wire wb_cyc_in,
   input wire wb_stb_in,
   input wire wb_we_in,
   input wire [9:0] wb_adr_in,
   input wire [3:0] wb_sel_in,
   input wire [31:0] wb_dat_in,
   input wire [31:0] wb_dat_out,
   input wire wb_ack_out,
   input wire [1:0] channel_out,
   input wire irq_out
);
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (!arst_n_in);
   // ----
   // control shadows, tracked from acked writes
   // ----
   reg [7:0] ctl1_q;
   reg [7:0] ctl2_q;
   wire [7:0] idx = wb_adr_in[9:2];
   wire unmapped = (idx < 8'hda) || (idx > 8'heb) || (idx > 8'hdf && idx < 8'he6);
   wire hold1 = !ctl1_q[2] && ctl1_q[5:3] != 3'h7;
   wire hold2 = !ctl2_q[2];
   wire mask_any = ctl1_q[6] || ctl2_q[6];
   always @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         ctl1_q <= 8'h40;
         ctl2_q <= 8'h40;
      end else if (wb_ack_out && wb_we_in && wb_sel_in[0]) begin
         if (idx == 8'he6) ctl1_q <= wb_dat_in[7:0];
         if (idx == 8'he7) ctl2_q <= wb_dat_in[7:0];
      end
   end
   // ----
   // properties
   // ----
   sequence s_req; wb_cyc_in && wb_stb_in && !wb_ack_out; endsequence
   sequence s_read; wb_ack_out && !wb_we_in; endsequence
   property p_ack_next; s_req |=> wb_ack_out; endproperty
   a_ack_next: assert property (p_ack_next) else $error("ack not one cycle after request");
   property p_ack_pulse; wb_ack_out |=> !wb_ack_out; endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
   property p_ack_cause; wb_ack_out |-> $past(wb_cyc_in && wb_stb_in); endproperty
   a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
   property p_rd_hi; s_read |-> wb_dat_out[31:8] == 24'h0; endproperty
   a_rd_hi: assert property (p_rd_hi) else $error("read data upper bits set");
   property p_unmapped; s_read and unmapped |-> wb_dat_out == 32'h0; endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   property p_ctl_read; s_read and idx[7:1] == 7'h73 |-> wb_dat_out[7:0] == (idx[0] ? ctl2_q : ctl1_q); endproperty
   a_ctl_read: assert property (p_ctl_read) else $error("control readback wrong");
   // irq is registered, so one cycle of lag after a mask write is allowed
   property p_irq_mask; irq_out |-> mask_any || $past(mask_any); endproperty
   a_irq_mask: assert property (p_irq_mask) else $error("irq while masked");
   property p_out1_hold; hold1 && $past(hold1) && $past(hold1, 2) |-> $stable(channel_out[0]); endproperty
   a_out1_hold: assert property (p_out1_hold) else $error("ch1 output moved in capture mode");
   property p_out2_hold; hold2 && $past(hold2) && $past(hold2, 2) |-> $stable(channel_out[1]); endproperty
   a_out2_hold: assert property (p_out2_hold) else $error("ch2 output moved in capture mode");
endmodule // tcc_capcmp_asserts
bind tcc_timer_capcmp tcc_capcmp_asserts u_chk (.sys_clk_in, .arst_n_in, .wb_cyc_in, .wb_stb_in, .wb_we_in,
   .wb_adr_in, .wb_sel_in, .wb_dat_in, .wb_dat_out, .wb_ack_out, .channel_out, .irq_out);

// ---- verif/tcc_pin_model.sv ----
`timescale 1ns/1ps
module tcc_pin_model (
   input wire sys_clk_in,
   output reg [1:0] capture_pin_out,
   output reg radio_event_out
);
   initial begin
      capture_pin_out = 2'h0;
      radio_event_out = 1'b0;
   end
   // levels move just after an edge, the block samples them synchronously
   task drive(input [1:0] pins, input radio);
      begin
         @(posedge sys_clk_in);
         capture_pin_out <= pins;
         radio_event_out <= radio;
      end
   endtask
endmodule // tcc_pin_model

// ---- verif/tcc_timer_capcmp_tb.sv ----
`timescale 1ns/1ps
module tcc_timer_capcmp_tb;
   reg clk, rst_n, cyc, stb, we;
   reg [9:0] adr;
   reg [3:0] sel;
   reg [31:0] dat, r;
   wire [31:0] rdat;
   wire ack, irq, radio;
   wire [1:0] pins, chout;
   integer mismatches, checks, seed, i, c, n0, n1;
   integer code_t[0:5] = '{0, 1, 3, 4, 5, 6};
   integer hi_t[0:5] = '{17, 0, 12, 5, 11, 6};
   reg [7:0] expq[$];
   tcc_timer_capcmp dut (.sys_clk_in(clk), .arst_n_in(rst_n), .wb_cyc_in(cyc), .wb_stb_in(stb),
      .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(dat), .wb_dat_out(rdat),
      .wb_ack_out(ack), .capture_pin_in(pins), .radio_interrupt_event_in(radio),
      .channel_out(chout), .irq_out(irq));
   tcc_pin_model pm (.sys_clk_in(clk), .capture_pin_out(pins), .radio_event_out(radio));
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // ----
   // bus cycles and comparisons
   // ----
   task check(input [31:0] seen, input [31:0] exp);
      begin
         checks = checks + 1;
         if (seen !== exp) begin
            mismatches = mismatches + 1;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
         end
      end
   endtask
   task bus(input w, input [7:0] idx, input [7:0] d);
      begin
         @(posedge clk);
         {cyc, stb, we, adr, sel, dat} <= {2'b11, w, idx, 2'b00, 4'hf, 24'h0, d};
         do @(posedge clk); while (ack !== 1'b1);
         {cyc, stb, we} <= 3'b000;
      end
   endtask
   task rd(input [7:0] idx, input [7:0] e);
      begin
         expq.push_back(e);
         bus(1'b0, idx, 8'h00);
      end
   endtask
   task span(input integer len);
      begin
         n0 = 0;
         n1 = 0;
         repeat (len) begin
            @(posedge clk);
            n0 = n0 + chout[0];
            n1 = n1 + chout[1];
         end
      end
   endtask
   task print_verdict;
      begin
         $display("checks %0d mismatches %0d", checks, mismatches);
         if (mismatches == 0 && checks > 0) $display("Run complete: PASS");
         else $display("Run complete: FAIL");
         $finish;
      end
   endtask
   always @(posedge clk) begin
      if (ack === 1'b1 && we === 1'b0 && expq.size() > 0) check(rdat, {24'h0, expq.pop_front()});
   end
   initial begin
      #2000000;
      mismatches = mismatches + 1;
      print_verdict;
   end
   // ----
   // scenarios
   // ----
   initial begin
      mismatches = 0;
      checks = 0;
      seed = 32'h4253;
      {cyc, stb, we, adr, sel, dat} = 49'h0;
      rst_n = 1'b0;
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      rd(8'he6, 8'h40);
      rd(8'he7, 8'h40);
      rd(8'hdd, 8'h00);
      rd(8'hdf, 8'h00);
      bus(1'b1, 8'h30, 8'h5a);
      rd(8'h30, 8'h00);
      for (i = 0; i < 4; i = i + 1) begin
         r = $random(seed);
         bus(1'b1, 8'hdc, r[7:0]);
         bus(1'b1, 8'hdd, r[15:8]);
         bus(1'b1, 8'hdf, r[23:16]);
         rd(8'hdc, r[7:0]);
         rd(8'hdd, r[15:8]);
         rd(8'hdf, r[23:16]);
      end
      // top 16, both channels match at 5
      bus(1'b1, 8'hda, 8'h10);
      bus(1'b1, 8'hdb, 8'h00);
      bus(1'b1, 8'hdc, 8'h05);
      bus(1'b1, 8'hdd, 8'h00);
      bus(1'b1, 8'hde, 8'h05);
      bus(1'b1, 8'hdf, 8'h00);
      bus(1'b1, 8'he8, 8'h02);
      for (i = 0; i < 6; i = i + 1) begin
         bus(1'b1, 8'he6, {2'b01, code_t[i][2:0], 3'b100});
         bus(1'b1, 8'he7, {2'b01, code_t[i][2:0], 3'b100});
         repeat (40) @(posedge clk);
         span(17);
         check(n0, hi_t[i]);
         check(n1, hi_t[i]);
      end
      bus(1'b1, 8'he6, 8'h54);
      bus(1'b1, 8'he7, 8'h54);
      repeat (20) @(posedge clk);
      r[1:0] = chout;
      repeat (17) @(posedge clk);
      check(chout, {30'h0, ~r[1:0]});
      check(irq, 1);
      bus(1'b1, 8'he8, 8'h03);
      for (i = 2; i < 4; i = i + 1) begin
         bus(1'b1, 8'he6, {2'b01, code_t[i][2:0], 3'b100});
         repeat (40) @(posedge clk);
         span(32);
         check(n0, (i == 2) ? 22 : 10);
      end
      // stopped counter at zero makes every capture read back as zero
      bus(1'b1, 8'he8, 8'h00);
      bus(1'b1, 8'he9, 8'h00);
      for (c = 0; c < 4; c = c + 1) begin
         bus(1'b1, 8'he6, {6'b010000, c[1:0]});
         for (i = 0; i < 2; i = i + 1) begin
            bus(1'b1, 8'hdc, 8'hff);
            bus(1'b1, 8'heb, 8'h00);
            pm.drive({1'b0, ~i[0]}, 1'b0);
            repeat (3) @(posedge clk);
            rd(8'heb, {7'h0, c[i]});
            rd(8'hdc, c[i] ? 8'h00 : 8'hff);
         end
      end
      bus(1'b1, 8'he6, 8'hc1);
      bus(1'b1, 8'he7, 8'hc1);
      bus(1'b1, 8'heb, 8'h00);
      pm.drive(2'b11, 1'b0);
      repeat (3) @(posedge clk);
      rd(8'heb, 8'h00);
      pm.drive(2'b11, 1'b1);
      repeat (3) @(posedge clk);
      rd(8'heb, 8'h03);
      check(irq, 1);
      bus(1'b1, 8'he6, 8'h81);
      bus(1'b1, 8'he7, 8'h81);
      repeat (2) @(posedge clk);
      check(irq, 0);
      bus(1'b1, 8'heb, 8'h03);
      rd(8'heb, 8'h03);
      bus(1'b1, 8'heb, 8'h02);
      rd(8'heb, 8'h02);
      bus(1'b1, 8'he7, 8'h41);
      bus(1'b1, 8'heb, 8'h00);
      pm.drive(2'b00, 1'b0);
      pm.drive(2'b10, 1'b0);
      repeat (3) @(posedge clk);
      rd(8'heb, 8'h02);
      check(irq, 1);
      // half-scale data gives one bit in two; low two data bits are ignored
      bus(1'b1, 8'hdc, 8'h03);
      bus(1'b1, 8'hdd, 8'h80);
      bus(1'b1, 8'he6, 8'h7d);
      repeat (40) @(posedge clk);
      span(32);
      check(n0, 16);
      // quarter-scale data, slow rate, no interpolator and no shaping
      bus(1'b1, 8'hdd, 8'h40);
      bus(1'b1, 8'he6, 8'h7b);
      repeat (40) @(posedge clk);
      span(32);
      check(n0, 8);
      print_verdict;
   end
endmodule // tcc_timer_capcmp_tb
